//--- verilog/lcdd_pkg.sv
// Constants shared by the segment LCD driver and its cell memory.
// Assumes a 32-bit APB slave on pclk and a slow sub-oscillator pin.
package lcdd_pkg;

  // ==========================================================================
  // Geometry
  localparam int unsigned SEG_COUNT = 32;
  localparam int unsigned COM_COUNT = 4;
  localparam int unsigned CELL_W    = 4;
  localparam int unsigned PTR_W     = 5;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [11:0] OFS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_POINTER = 12'h004;
  localparam logic [11:0] OFS_CELL    = 12'h008;
  localparam logic [11:0] OFS_BOOSTER = 12'h00c;

  // Control fields
  localparam int unsigned CTL_BIAS    = 7;
  localparam int unsigned CTL_DUTY_HI = 6;
  localparam int unsigned CTL_DUTY_LO = 5;
  localparam int unsigned CTL_ENABLE  = 4;
  localparam int unsigned CTL_WAVE    = 2;
  localparam int unsigned CTL_RATE_HI = 1;
  localparam int unsigned CTL_RATE_LO = 0;
  // Booster fields
  localparam int unsigned BST_RATE_HI = 2;
  localparam int unsigned BST_RATE_LO = 1;

  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [7:0] POINTER_RST  = 8'h00;
  localparam logic [7:0] BOOSTER_RST  = 8'h00;
  localparam logic [7:0] CONTROL_MASK = 8'hf7;
  localparam logic [7:0] POINTER_MASK = 8'h1f;
  localparam logic [7:0] CELL_MASK    = 8'h0f;
  localparam logic [7:0] BOOSTER_MASK = 8'h06;

  // ==========================================================================
  // Drive level codes on each com/seg output
  localparam logic [1:0] LVL_GND  = 2'h0;
  localparam logic [1:0] LVL_LOW  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_VDD  = 2'h3;

  // Duty codes and last common index per duty
  localparam logic [1:0] DUTY_HALF    = 2'h0;
  localparam logic [1:0] DUTY_THIRD   = 2'h1;
  localparam logic [1:0] LAST_COM_D2  = 2'h1;
  localparam logic [1:0] LAST_COM_D3  = 2'h2;
  localparam logic [1:0] LAST_COM_D4  = 2'h3;

  // Sub-clock ticks per common slot, by frame-rate code and duty
  localparam logic [8:0] SLOT_R0_D2 = 9'h100;
  localparam logic [8:0] SLOT_R0_D3 = 9'h0ac;
  localparam logic [8:0] SLOT_R0_D4 = 9'h080;
  localparam logic [8:0] SLOT_R1_D2 = 9'h118;
  localparam logic [8:0] SLOT_R1_D3 = 9'h0bc;
  localparam logic [8:0] SLOT_R1_D4 = 9'h08c;
  localparam logic [8:0] SLOT_R2_D2 = 9'h130;
  localparam logic [8:0] SLOT_R2_D3 = 9'h0cc;
  localparam logic [8:0] SLOT_R2_D4 = 9'h098;
  localparam logic [8:0] SLOT_R3_D2 = 9'h0e8;
  localparam logic [8:0] SLOT_R3_D3 = 9'h09c;
  localparam logic [8:0] SLOT_R3_D4 = 9'h074;

  // Booster: half period in sub-clock ticks for codes 01, 10, 11
  localparam logic [1:0] BST_DIV1      = 2'h0;
  localparam logic [3:0] BST_HALF_DIV4  = 4'h2;
  localparam logic [3:0] BST_HALF_DIV8  = 4'h4;
  localparam logic [3:0] BST_HALF_DIV16 = 4'h8;

  typedef enum logic [1:0] {
    LCDD_ST_OFF  = 2'b01,
    LCDD_ST_SCAN = 2'b10
  } lcdd_state_t;

endpackage : lcdd_pkg

//--- verilog/lcdd_cell_ram.sv
// Display cell memory: 32 entries of 4 bits, one per segment line.
// Assumes one write port from the register bus; both reads are registered.
`timescale 1ns/1ps
`default_nettype none
module lcdd_cell_ram (
  // Clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // Software port
  input  wire logic                            wr_en,
  input  wire logic [lcdd_pkg::PTR_W-1:0]      addr,
  input  wire logic [lcdd_pkg::CELL_W-1:0]     wr_data,
  output var  logic [lcdd_pkg::CELL_W-1:0]     rd_data,
  // Scan port: one bit per segment for the chosen common
  input  wire logic [1:0]                      col_sel,
  output var  logic [lcdd_pkg::SEG_COUNT-1:0]  col_bits
);

  logic [lcdd_pkg::SEG_COUNT-1:0][lcdd_pkg::CELL_W-1:0] cells_ff;
  logic [lcdd_pkg::SEG_COUNT-1:0][lcdd_pkg::CELL_W-1:0] nxt_cells;
  logic [lcdd_pkg::SEG_COUNT-1:0]                       nxt_col;

  always_comb begin
    nxt_cells = cells_ff;
    if (wr_en) begin
      nxt_cells[addr] = wr_data;
    end
    for (int j = 0; j < lcdd_pkg::SEG_COUNT; j++) begin
      nxt_col[j] = cells_ff[j][col_sel];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cells_ff <= '0;
      rd_data  <= '0;
      col_bits <= '0;
    end else begin
      cells_ff <= nxt_cells;
      rd_data  <= cells_ff[addr];
      col_bits <= nxt_col;
    end
  end

endmodule : lcdd_cell_ram
`default_nettype wire

//--- verilog/lcdd_core.sv
// Segment LCD driver: APB registers, cell memory, frame timing, drive levels.
// Assumes sub_clk_pin is a free-running slow oscillator far below pclk.
//
// Overview of operation
// - The matrix is 32 segment lines by 4 common lines, 128 dots in all.
// - Display keeps running in normal, green and idle modes; no mode input stops it.
// - All frame timing counts edges of the sub-oscillator clock.
// - Control bit 7 picks half bias when 0 and third bias when 1.
// - Duty bits 6:5 pick half duty for 00, third for 01, quarter when bit 6 is 1.
// - Control bit 4 enables the display; when clear every output sits at ground.
// - Control bit 2 picks the A-type waveform when 0 and B-type when 1.
// - Rate codes 00 and 01 divide Fs by 256x2/172x3/128x4 and 280x2/188x3/140x4.
// - Rate codes 10 and 11 divide Fs by 304x2/204x3/152x4 and 232x2/156x3/116x4.
// - The pointer register holds a 5-bit segment index; its upper bits read zero.
// - The cell buffer carries four bits, bit n for common n; upper bits unused.
// - Booster bits 2:1 clock the charge pump at Fs divided by 1, 4, 8 or 16.
// - The booster rate is software adjustable to strengthen the middle levels.
`timescale 1ns/1ps
`default_nettype none
module lcdd_core (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output var  logic [31:0]  prdata,
  output var  logic         pready,
  output var  logic         pslverr,
  // Sub-oscillator pin
  input  wire logic         sub_clk_pin,
  // Glass drive, two bits per line
  output var  logic [7:0]   com_level,
  output var  logic [63:0]  seg_level,
  output var  logic         booster_clk
);

  // ==========================================================================
  // Helpers
  function automatic logic [8:0] slot_len(input logic [1:0] rate, input logic [1:0] duty);
    logic [8:0] d2, d3, d4;
    case (rate)
      2'h0: begin d2 = lcdd_pkg::SLOT_R0_D2; d3 = lcdd_pkg::SLOT_R0_D3; d4 = lcdd_pkg::SLOT_R0_D4; end
      2'h1: begin d2 = lcdd_pkg::SLOT_R1_D2; d3 = lcdd_pkg::SLOT_R1_D3; d4 = lcdd_pkg::SLOT_R1_D4; end
      2'h2: begin d2 = lcdd_pkg::SLOT_R2_D2; d3 = lcdd_pkg::SLOT_R2_D3; d4 = lcdd_pkg::SLOT_R2_D4; end
      default: begin d2 = lcdd_pkg::SLOT_R3_D2; d3 = lcdd_pkg::SLOT_R3_D3; d4 = lcdd_pkg::SLOT_R3_D4; end
    endcase
    if (duty[1]) begin
      return d4;
    end else if (duty == lcdd_pkg::DUTY_THIRD) begin
      return d3;
    end
    return d2;
  endfunction : slot_len

  function automatic logic [1:0] last_com(input logic [1:0] duty);
    if (duty[1]) begin
      return lcdd_pkg::LAST_COM_D4;
    end else if (duty == lcdd_pkg::DUTY_THIRD) begin
      return lcdd_pkg::LAST_COM_D3;
    end
    return lcdd_pkg::LAST_COM_D2;
  endfunction : last_com

  function automatic logic [3:0] boost_half(input logic [1:0] code);
    case (code)
      2'h1:    return lcdd_pkg::BST_HALF_DIV4;
      2'h2:    return lcdd_pkg::BST_HALF_DIV8;
      default: return lcdd_pkg::BST_HALF_DIV16;
    endcase
  endfunction : boost_half

  // ==========================================================================
  // Register bus
  logic [7:0]  control_ff, pointer_ff, booster_ff;
  logic [7:0]  nxt_control, nxt_pointer, nxt_booster;
  logic [31:0] nxt_prdata;
  logic        nxt_pready, nxt_pslverr;
  logic        cell_wr;
  logic [3:0]  cell_rd;
  logic [31:0] col_bits;
  logic        access, commit, hit;

  always_comb begin
    access      = psel && penable;
    commit      = access && pready;
    hit         = (paddr == lcdd_pkg::OFS_CONTROL) || (paddr == lcdd_pkg::OFS_POINTER) ||
                  (paddr == lcdd_pkg::OFS_CELL) || (paddr == lcdd_pkg::OFS_BOOSTER);
    nxt_control = control_ff;
    nxt_pointer = pointer_ff;
    nxt_booster = booster_ff;
    nxt_prdata  = prdata;
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    cell_wr     = 1'b0;
    // One wait state lets the registered memory read settle
    if (access && !pready) begin
      nxt_pready  = 1'b1;
      nxt_pslverr = !hit;
      nxt_prdata  = '0;
      case (paddr)
        lcdd_pkg::OFS_CONTROL: nxt_prdata[7:0] = control_ff;
        lcdd_pkg::OFS_POINTER: nxt_prdata[7:0] = pointer_ff;
        lcdd_pkg::OFS_CELL:    nxt_prdata[3:0] = cell_rd;
        lcdd_pkg::OFS_BOOSTER: nxt_prdata[7:0] = booster_ff;
        default:               nxt_prdata      = '0;
      endcase
    end
    if (commit && pwrite) begin
      case (paddr)
        lcdd_pkg::OFS_CONTROL: nxt_control = pwdata[7:0] & lcdd_pkg::CONTROL_MASK;
        lcdd_pkg::OFS_POINTER: nxt_pointer = pwdata[7:0] & lcdd_pkg::POINTER_MASK;
        lcdd_pkg::OFS_CELL:    cell_wr     = 1'b1;
        lcdd_pkg::OFS_BOOSTER: nxt_booster = pwdata[7:0] & lcdd_pkg::BOOSTER_MASK;
        default:               cell_wr     = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_ff <= lcdd_pkg::CONTROL_RST;
      pointer_ff <= lcdd_pkg::POINTER_RST;
      booster_ff <= lcdd_pkg::BOOSTER_RST;
      prdata     <= '0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      control_ff <= nxt_control;
      pointer_ff <= nxt_pointer;
      booster_ff <= nxt_booster;
      prdata     <= nxt_prdata;
      pready     <= nxt_pready;
      pslverr    <= nxt_pslverr;
    end
  end

  // ==========================================================================
  // Cell memory
  logic [1:0] com_idx_ff;

  lcdd_cell_ram u_cells (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (cell_wr),
    .addr     (pointer_ff[lcdd_pkg::PTR_W-1:0]),
    .wr_data  (pwdata[lcdd_pkg::CELL_W-1:0]),
    .rd_data  (cell_rd),
    .col_sel  (com_idx_ff),
    .col_bits (col_bits)
  );

  // ==========================================================================
  // Sub-oscillator synchroniser and tick
  logic sub_meta_ff, sub_sync_ff, sub_prev_ff;
  logic fs_tick;

  // sample the slow clock, one tick per rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_meta_ff <= 1'b0;
      sub_sync_ff <= 1'b0;
      sub_prev_ff <= 1'b0;
    end else begin
      sub_meta_ff <= sub_clk_pin;
      sub_sync_ff <= sub_meta_ff;
      sub_prev_ff <= sub_sync_ff;
    end
  end
  assign fs_tick = sub_sync_ff && !sub_prev_ff;

  // ==========================================================================
  // Frame timing
  lcdd_pkg::lcdd_state_t state_ff;
  lcdd_pkg::lcdd_state_t nxt_state;
  logic [8:0] tick_cnt_ff, nxt_tick_cnt, slot;
  logic [1:0] nxt_com_idx, duty;
  logic       frame_pol_ff, nxt_frame_pol, enabled;

  always_comb begin
    duty          = {control_ff[lcdd_pkg::CTL_DUTY_HI], control_ff[lcdd_pkg::CTL_DUTY_LO]};
    slot          = slot_len({control_ff[lcdd_pkg::CTL_RATE_HI],
                              control_ff[lcdd_pkg::CTL_RATE_LO]}, duty);
    enabled       = control_ff[lcdd_pkg::CTL_ENABLE];
    nxt_state     = state_ff;
    nxt_tick_cnt  = tick_cnt_ff;
    nxt_com_idx   = com_idx_ff;
    nxt_frame_pol = frame_pol_ff;
    case (state_ff)
      lcdd_pkg::LCDD_ST_OFF: begin
        nxt_tick_cnt  = '0;
        nxt_com_idx   = '0;
        nxt_frame_pol = 1'b0;
        if (enabled) begin
          nxt_state = lcdd_pkg::LCDD_ST_SCAN;
        end
      end
      lcdd_pkg::LCDD_ST_SCAN: begin
        if (!enabled) begin
          nxt_state = lcdd_pkg::LCDD_ST_OFF;
        end else if (fs_tick) begin
          // step commons, wrap at frame end
          if (tick_cnt_ff >= slot - 9'h001) begin
            nxt_tick_cnt = '0;
            if (com_idx_ff >= last_com(duty)) begin
              nxt_com_idx   = '0;
              nxt_frame_pol = !frame_pol_ff;
            end else begin
              nxt_com_idx = com_idx_ff + 2'h1;
            end
          end else begin
            nxt_tick_cnt = tick_cnt_ff + 9'h001;
          end
        end
      end
      default: nxt_state = lcdd_pkg::LCDD_ST_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= lcdd_pkg::LCDD_ST_OFF;
      tick_cnt_ff  <= '0;
      com_idx_ff   <= '0;
      frame_pol_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      tick_cnt_ff  <= nxt_tick_cnt;
      com_idx_ff   <= nxt_com_idx;
      frame_pol_ff <= nxt_frame_pol;
    end
  end

  // ==========================================================================
  // Drive levels
  logic [7:0]  nxt_com_level;
  logic [63:0] nxt_seg_level;
  logic        pol, third;

  always_comb begin
    // A flips inside each slot, B flips once per frame
    pol   = control_ff[lcdd_pkg::CTL_WAVE] ? frame_pol_ff
                                           : (tick_cnt_ff >= {1'b0, slot[8:1]});
    third = control_ff[lcdd_pkg::CTL_BIAS];
    nxt_com_level = '0;
    nxt_seg_level = '0;
    if (state_ff == lcdd_pkg::LCDD_ST_SCAN && enabled) begin
      // unused commons stay at the unselected level
      for (int i = 0; i < lcdd_pkg::COM_COUNT; i++) begin
        if (2'(i) == com_idx_ff) begin
          nxt_com_level[2*i +: 2] = pol ? lcdd_pkg::LVL_VDD : lcdd_pkg::LVL_GND;
        end else if (third) begin
          nxt_com_level[2*i +: 2] = pol ? lcdd_pkg::LVL_LOW : lcdd_pkg::LVL_HIGH;
        end else begin
          nxt_com_level[2*i +: 2] = lcdd_pkg::LVL_LOW;
        end
      end
      // on cells take the opposite rail
      for (int j = 0; j < lcdd_pkg::SEG_COUNT; j++) begin
        if (col_bits[j]) begin
          nxt_seg_level[2*j +: 2] = pol ? lcdd_pkg::LVL_GND : lcdd_pkg::LVL_VDD;
        end else if (third) begin
          nxt_seg_level[2*j +: 2] = pol ? lcdd_pkg::LVL_HIGH : lcdd_pkg::LVL_LOW;
        end else begin
          nxt_seg_level[2*j +: 2] = pol ? lcdd_pkg::LVL_VDD : lcdd_pkg::LVL_GND;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      com_level <= '0;
      seg_level <= '0;
    end else begin
      com_level <= nxt_com_level;
      seg_level <= nxt_seg_level;
    end
  end

  // ==========================================================================
  // Charge-pump booster clock
  logic [3:0] bst_cnt_ff;
  logic [3:0] nxt_bst_cnt;
  logic       nxt_booster_clk;
  logic [1:0] bst_code;

  always_comb begin
    bst_code        = {booster_ff[lcdd_pkg::BST_RATE_HI], booster_ff[lcdd_pkg::BST_RATE_LO]};
    nxt_bst_cnt     = bst_cnt_ff;
    nxt_booster_clk = booster_clk;
    // Pump only while the glass is driven, saves the supply otherwise
    if (!enabled) begin
      nxt_bst_cnt     = '0;
      nxt_booster_clk = 1'b0;
    end else if (bst_code == lcdd_pkg::BST_DIV1) begin
      // full rate follows the synchronised clock
      nxt_bst_cnt     = '0;
      nxt_booster_clk = sub_sync_ff;
    end else if (fs_tick) begin
      if (bst_cnt_ff >= boost_half(bst_code) - 4'h1) begin
        nxt_bst_cnt     = '0;
        nxt_booster_clk = !booster_clk;
      end else begin
        nxt_bst_cnt = bst_cnt_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bst_cnt_ff  <= '0;
      booster_clk <= 1'b0;
    end else begin
      bst_cnt_ff  <= nxt_bst_cnt;
      booster_clk <= nxt_booster_clk;
    end
  end

endmodule : lcdd_core
`default_nettype wire

//--- verif/lcdd_core_asserts.sv
// Checker for the segment LCD driver, bound to lcdd_core ports.
// Assumes software clears enable before it changes bias or duty.
`timescale 1ns/1ps
`default_nettype none
module lcdd_core_asserts (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Glass drive
  input wire logic [7:0]  com_level,
  input wire logic [63:0] seg_level,
  input wire logic        booster_clk
);
  // ====================
  // Control shadow, updated at the same commit edge as the design
  logic [7:0] ctl_ff;
  logic [7:0] nxt_ctl;
  logic [7:0] rd_mask;
  logic [2:0] sel_cnt;
  logic       mapped;
  logic       mid2;
  logic       seg_mid;
  always_comb begin
    nxt_ctl = ctl_ff;
    if (psel && penable && pready && pwrite && paddr == lcdd_pkg::OFS_CONTROL) begin
      nxt_ctl = pwdata[7:0] & lcdd_pkg::CONTROL_MASK;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= 8'h00;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end
  always_comb begin
    mapped = paddr inside {lcdd_pkg::OFS_CONTROL, lcdd_pkg::OFS_POINTER,
                           lcdd_pkg::OFS_CELL, lcdd_pkg::OFS_BOOSTER};
    case (paddr)
      lcdd_pkg::OFS_CONTROL: rd_mask = lcdd_pkg::CONTROL_MASK;
      lcdd_pkg::OFS_POINTER: rd_mask = lcdd_pkg::POINTER_MASK;
      lcdd_pkg::OFS_CELL:    rd_mask = lcdd_pkg::CELL_MASK;
      lcdd_pkg::OFS_BOOSTER: rd_mask = lcdd_pkg::BOOSTER_MASK;
      default:               rd_mask = 8'h00;
    endcase
    sel_cnt = 3'h0;
    mid2 = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (com_level[2*i +: 2] inside {2'h0, 2'h3}) sel_cnt = sel_cnt + 3'h1;
      if (com_level[2*i +: 2] == 2'h2) mid2 = 1'b1;
    end
    seg_mid = 1'b0;
    for (int j = 0; j < 32; j++) begin
      if (seg_level[2*j +: 2] inside {2'h1, 2'h2}) seg_mid = 1'b1;
    end
  end
  // ====================
  // Properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  off_ground_a:
    assert property ((!ctl_ff[4]) [*3] |-> com_level == 8'h00 && seg_level == 64'h0 && !booster_clk)
    else $error("outputs not grounded while disabled");
  half_bias_a:
    assert property ((ctl_ff[4] && !ctl_ff[7]) [*4] |-> !mid2 && !seg_mid)
    else $error("third bias level seen at half bias");
  duty_unsel_a:
    assert property ((ctl_ff[4] && !ctl_ff[6]) [*4] |-> com_level[7:6] inside {2'h1, 2'h2}
                     && (ctl_ff[5] || com_level[5:4] inside {2'h1, 2'h2}))
    else $error("common beyond duty selected");
  one_sel_a:
    assert property (ctl_ff[4] [*4] |-> sel_cnt == 3'h1)
    else $error("not exactly one common selected");
  rdy_pulse_a:
    assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  wait_state_a:
    assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("access not answered after one wait state");
  err_decode_a:
    assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match decode");
  rd_zero_a:
    assert property (pready && !pwrite |-> prdata[31:8] == 24'h0 && (prdata[7:0] & ~rd_mask) == 8'h00)
    else $error("unused read bits not zero");
  ctl_echo_a:
    assert property (pready && !pwrite && paddr == lcdd_pkg::OFS_CONTROL |-> prdata[7:0] == ctl_ff)
    else $error("control readback differs from last write");
endmodule : lcdd_core_asserts
bind lcdd_core lcdd_core_asserts u_lcdd_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .com_level(com_level), .seg_level(seg_level), .booster_clk(booster_clk)
);
`default_nettype wire

//--- verif/lcdd_glass_model.sv
// Passive four-common glass: flags dots that see full drive swing.
// Assumes the level codes 0 and 3 are ground and supply.
`timescale 1ns/1ps
`default_nettype none
module lcdd_glass_model (
  // Drive from the controller
  input  wire logic [7:0]   com_level,
  input  wire logic [63:0]  seg_level,
  // Dot index is 4*segment+common
  output var  logic [127:0] dot_on
);
  // ====================
  // Only full-swing instants count; RMS averaging is not modelled
  always_comb begin
    for (int s = 0; s < 32; s++) begin
      for (int c = 0; c < 4; c++) begin
        dot_on[4*s+c] = {com_level[2*c +: 2], seg_level[2*s +: 2]} inside {4'h3, 4'hc};
      end
    end
  end
endmodule : lcdd_glass_model
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the segment LCD driver with a glass model.
// Assumes a fast sub-oscillator so whole frames fit in a short run.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ====================
  // Signals
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic         sub_clk, booster_clk;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata;
  logic [7:0]   com_level;
  logic [63:0]  seg_level;
  logic [127:0] dot_on;
  logic [3:0]   ram_sh [32];
  int           err_total, checks, sub_ticks;
  logic [11:0]  offs [4] = '{lcdd_pkg::OFS_CONTROL, lcdd_pkg::OFS_POINTER,
                            lcdd_pkg::OFS_CELL, lcdd_pkg::OFS_BOOSTER};
  logic [7:0]   msk [4] = '{lcdd_pkg::CONTROL_MASK, lcdd_pkg::POINTER_MASK,
                           lcdd_pkg::CELL_MASK, lcdd_pkg::BOOSTER_MASK};
  lcdd_core dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sub_clk_pin(sub_clk), .com_level(com_level), .seg_level(seg_level),
    .booster_clk(booster_clk)
  );
  lcdd_glass_model u_glass (.com_level(com_level), .seg_level(seg_level), .dot_on(dot_on));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Edges never meet pclk edges, so the tick count is race free
  initial begin
    sub_clk = 1'b0;
    #13;
    forever #32 sub_clk = ~sub_clk;
  end
  always @(posedge sub_clk) sub_ticks++;
  // ====================
  // Helpers
  function automatic int slot_len(input int r, input int d);
    int t [4][3] = '{'{256, 172, 128}, '{280, 188, 140}, '{304, 204, 152}, '{232, 156, 116}};
    return t[r][(d > 2) ? 2 : d];
  endfunction : slot_len
  function automatic logic [2:0] sel_idx(input logic [7:0] c);
    sel_idx = 3'h4;
    for (int i = 0; i < 4; i++) if (c[2*i +: 2] inside {2'h0, 2'h3}) sel_idx = 3'(i);
  endfunction : sel_idx
  task automatic end_of_test();
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  task automatic hang();
    err_total++;
    $display("ERROR wait expected done seen timeout");
    end_of_test();
  endtask : hang
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, {24'h0, exp}, r);
  endtask : rd_chk
  // Disable first so the scan restarts cleanly on the new settings
  task automatic cfg(input logic [7:0] c);
    int n;
    n = 0;
    wr(lcdd_pkg::OFS_CONTROL, 32'h0);
    repeat (4) @(posedge pclk);
    wr(lcdd_pkg::OFS_CONTROL, {24'h0, c});
    while (com_level === 8'h00 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) hang();
  endtask : cfg
  // Ticks between two level changes, after skipping a partial one
  task automatic slot_meas(output int k);
    logic [7:0] c0;
    int         t0, n;
    n = 0;
    for (int ph = 0; ph < 2; ph++) begin
      c0 = com_level;
      t0 = sub_ticks;
      while (com_level === c0 && n < 8000) begin
        @(posedge pclk);
        n++;
      end
    end
    if (n >= 8000) hang();
    k = sub_ticks - t0;
  endtask : slot_meas
  // ====================
  // Main sequence
  initial begin
    logic [31:0] v, r;
    logic        e, pb;
    int          k, nb, t0, n;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    v = $urandom(44071);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i]) rd_chk("reset", offs[i], 8'h00);
    foreach (offs[i]) begin
      repeat (3) begin
        v = $urandom();
        if (i == 0) v[4] = 1'b0;
        wr(offs[i], v);
        rd_chk("reg", offs[i], v[7:0] & msk[i]);
      end
    end
    wr(lcdd_pkg::OFS_CONTROL, 32'h6b);
    apb(1'b1, 12'h100, 32'hff, r, e);
    chk("wr_err", 32'h1, {31'h0, e});
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk("rd_err", 32'h1, {31'h0, e});
    chk("rd_data", 32'h0, r);
    rd_chk("ctl", lcdd_pkg::OFS_CONTROL, 8'h63);
    for (int s = 0; s < 32; s++) begin
      v = $urandom();
      ram_sh[s] = v[3:0];
      wr(lcdd_pkg::OFS_POINTER, {24'h0, v[31:29], 5'(s)});
      rd_chk("ptr", lcdd_pkg::OFS_POINTER, {3'h0, 5'(s)});
      wr(lcdd_pkg::OFS_CELL, v);
      rd_chk("cell_new", lcdd_pkg::OFS_CELL, {4'h0, v[3:0]});
    end
    for (int s = 31; s >= 0; s--) begin
      wr(lcdd_pkg::OFS_POINTER, 32'(s));
      rd_chk("cell", lcdd_pkg::OFS_CELL, {4'h0, ram_sh[s]});
    end
    for (int rt = 0; rt < 4; rt++) begin
      for (int d = 0; d < 4; d++) begin
        v = $urandom();
        cfg({v[7], 2'(d), 1'b1, 1'b0, v[2], 2'(rt)});
        slot_meas(k);
        chk("slot", v[2] ? slot_len(rt, d) : slot_len(rt, d) / 2, k);
      end
    end
    cfg(8'hf7);
    for (int c = 0; c < 4; c++) begin
      n = 0;
      while (sel_idx(com_level) !== 3'(c) && n < 8000) begin
        @(posedge pclk);
        n++;
      end
      if (n >= 8000) hang();
      repeat (3) @(posedge pclk);
      for (int s = 0; s < 32; s++) begin
        v[s] = ram_sh[s][c];
        r[s] = dot_on[4*s+c];
      end
      chk("dots", v, r);
    end
    for (int b = 0; b < 4; b++) begin
      wr(lcdd_pkg::OFS_BOOSTER, 32'(b << 1));
      t0 = sub_ticks;
      nb = 0;
      n = 0;
      pb = booster_clk;
      while (sub_ticks - t0 < 64 && n < 2000) begin
        @(posedge pclk);
        n++;
        nb += (booster_clk && !pb) ? 1 : 0;
        pb = booster_clk;
      end
      if (n >= 2000) hang();
      k = 64 >> ((b == 0) ? 0 : b + 1);
      chk("booster", k, (nb >= k - 1 && nb <= k + 1) ? k : nb);
    end
    wr(lcdd_pkg::OFS_CONTROL, 32'h0);
    repeat (3) @(posedge pclk);
    chk("com_off", 32'h0, {24'h0, com_level});
    chk("seg_off", 32'h0, seg_level[31:0] | seg_level[63:32]);
    chk("bst_off", 32'h0, {31'h0, booster_clk});
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
